// ==== usd_pkg.sv ====
// constants for the uart shadow data port
package usd_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BAUD_DEFAULT = 115_200;
  localparam int unsigned CLKS_PER_BIT = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned RX_FIFO_DEPTH = 16;
  localparam int unsigned TX_FIFO_DEPTH = 16;
  localparam int unsigned CHAR_BITS = 8;

  localparam logic [31:0] SHADOW_DATA_2_ADDR = 32'h50001038;
  localparam logic [31:0] SHADOW_DATA_3_ADDR = 32'h5000103C;
  localparam logic [31:0] SHADOW_STRIDE = 32'h00000004;
  localparam logic [31:0] SHADOW_WORDS = 32'h00000010;
  localparam logic [31:0] SHADOW_BASE = SHADOW_DATA_2_ADDR - 2 * SHADOW_STRIDE;
  localparam logic [31:0] SHADOW_END = SHADOW_BASE
    + SHADOW_WORDS * SHADOW_STRIDE;

  localparam logic [31:0] FIFO_CONTROL_ADDR = 32'h50001080;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h50001084;
  localparam logic [31:0] INT_STATUS_ADDR = 32'h50001088;
  localparam logic [31:0] INT_MASK_ADDR = 32'h5000108C;

  localparam int unsigned FC_FIFO_EN_BIT = 0;
  localparam int unsigned FC_IR_MODE_BIT = 1;
  localparam int unsigned LS_DATA_READY_BIT = 0;
  localparam int unsigned LS_OVERRUN_BIT = 1;
  localparam int unsigned LS_TX_EMPTY_BIT = 5;

  localparam int unsigned INT_RX_BIT = 0;
  localparam int unsigned INT_OVERRUN_BIT = 1;
  localparam int unsigned INT_TX_EMPTY_BIT = 2;
  localparam int unsigned INT_TX_LOST_BIT = 3;
  localparam int unsigned INT_BITS = 4;

  localparam logic [31:0] DATA_RESET = 32'h00000000;
  localparam logic [INT_BITS-1:0] INT_RESET = 4'h0;
  localparam logic [7:0] CHAR_RESET = 8'h00;
endpackage

// ==== usd_shadow_port.sv ====
// uart shadow data port with rx/tx fifos, serial and infrared pins
// How it works
// - character sits in bits 7:0; bits 15:8 and above read zero.
// - sixteen aliased word locations all reach the same receive/transmit data.
// - receive from serial pin in uart mode, infrared pin in infrared mode.
// - fifos off, unread character is overwritten and overrun is flagged.
// - fifos on, a read returns the receive fifo head.
// - receive fifo full, new character dropped, contents kept, overrun flagged.
// - transmit on serial pin, or active-low infrared pin in infrared mode.
// - fifos off, one write clears the holding empty flag.
// - fifos off, further writes overwrite the pending transmit character.
// - fifos on, accepts writes up to the fifo depth, default sixteen.
// - writes while the transmit fifo is full are lost.
//
// Implementation choice: the address-and-strobe port.
module usd_shadow_port #(
  parameter int unsigned CLKS_PER_BIT = usd_pkg::CLKS_PER_BIT,
  parameter int unsigned RX_DEPTH = usd_pkg::RX_FIFO_DEPTH,
  parameter int unsigned TX_DEPTH = usd_pkg::TX_FIFO_DEPTH
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic SIN,
  input wire logic SIR_IN,
  output logic SOUT,
  output logic SIR_OUT_N,
  output logic IRQ
);
  localparam int RPW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int TPW = (TX_DEPTH > 1) ? $clog2(TX_DEPTH) : 1;
  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam logic [15:0] BIT_LAST = 16'(CLKS_PER_BIT - 1);
  localparam logic [15:0] HALF_LAST = 16'(CLKS_PER_BIT / 2 - 1);
  localparam logic [RCW-1:0] RX_FULL = RCW'(RX_DEPTH);
  localparam logic [TCW-1:0] TX_FULL = TCW'(TX_DEPTH);
  localparam int IW = usd_pkg::INT_BITS;
  typedef enum logic [1:0] {USD_IDLE, USD_START, USD_DATA, USD_STOP} usd_ser_t;
  typedef struct packed {
    logic [RX_DEPTH-1:0][7:0] rx_mem;
    logic [RPW-1:0] rx_rd;
    logic [RPW-1:0] rx_wr;
    logic [RCW-1:0] rx_cnt;
    logic [TX_DEPTH-1:0][7:0] tx_mem;
    logic [TPW-1:0] tx_rd;
    logic [TPW-1:0] tx_wr;
    logic [TCW-1:0] tx_cnt;
    logic fifo_en;
    logic ir_mode;
    logic overrun;
    logic [IW-1:0] int_stat;
    logic [IW-1:0] int_mask;
    logic [31:0] rdata;
    logic irq;
    logic sin_s1;
    logic sin_s2;
    logic ir_s1;
    logic ir_s2;
    usd_ser_t rx_st;
    logic [15:0] rx_baud;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    usd_ser_t tx_st;
    logic [15:0] tx_baud;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_line;
    logic sout;
    logic sir_out_n;
  } usd_state_t;

  usd_state_t state_reg;
  usd_state_t state_next;
  function automatic logic in_shadow(input logic [31:0] a);
    in_shadow = (a >= usd_pkg::SHADOW_BASE) && (a < usd_pkg::SHADOW_END)
      && (a[1:0] == 2'h0);
  endfunction
  function automatic logic [RPW-1:0] rx_inc(input logic [RPW-1:0] p);
    rx_inc = (32'(p) == RX_DEPTH - 1) ? '0 : RPW'(p + 1'b1);
  endfunction
  function automatic logic [TPW-1:0] tx_inc(input logic [TPW-1:0] p);
    tx_inc = (32'(p) == TX_DEPTH - 1) ? '0 : TPW'(p + 1'b1);
  endfunction

  always_comb
  begin
    logic rx_line;
    logic rx_done;
    logic rd_shadow;
    logic wr_shadow;
    logic [RCW-1:0] rx_cap;
    logic [TCW-1:0] tx_cap;
    logic [IW-1:0] ev;
    logic [7:0] head;
    rx_line = 1'b1;
    rx_done = 1'b0;
    rd_shadow = 1'b0;
    wr_shadow = 1'b0;
    rx_cap = '0;
    tx_cap = '0;
    ev = '0;
    head = 8'h00;
    state_next = state_reg;

    // synchronisers; only the second stage is read
    state_next.sin_s1 = SIN;
    state_next.sin_s2 = state_reg.sin_s1;
    state_next.ir_s1 = SIR_IN;
    state_next.ir_s2 = state_reg.ir_s1;
    // infrared input pulses high for a zero bit
    rx_line = state_reg.ir_mode ? ~state_reg.ir_s2 : state_reg.sin_s2;

    rd_shadow = RD && in_shadow(ADDR);
    wr_shadow = WR && in_shadow(ADDR);
    // without fifos the buffers act as a single holding slot
    rx_cap = state_reg.fifo_en ? RX_FULL : RCW'(1);
    tx_cap = state_reg.fifo_en ? TX_FULL : TCW'(1);

    // receive shifter, 8 data bits, one stop bit, mid-bit sampling
    case (state_reg.rx_st)
      USD_IDLE:
      begin
        state_next.rx_baud = 16'h0000;
        if (!rx_line)
          state_next.rx_st = USD_START;
      end
      USD_START:
      begin
        state_next.rx_baud = 16'(state_reg.rx_baud + 16'h0001);
        if (state_reg.rx_baud == HALF_LAST)
        begin
          state_next.rx_baud = 16'h0000;
          state_next.rx_bit = 3'h0;
          state_next.rx_st = rx_line ? USD_IDLE : USD_DATA;
        end
      end
      USD_DATA:
      begin
        state_next.rx_baud = 16'(state_reg.rx_baud + 16'h0001);
        if (state_reg.rx_baud == BIT_LAST)
        begin
          state_next.rx_baud = 16'h0000;
          state_next.rx_shift = {rx_line, state_reg.rx_shift[7:1]};
          state_next.rx_bit = 3'(state_reg.rx_bit + 3'h1);
          if (state_reg.rx_bit == 3'h7)
            state_next.rx_st = USD_STOP;
        end
      end
      USD_STOP:
      begin
        state_next.rx_baud = 16'(state_reg.rx_baud + 16'h0001);
        if (state_reg.rx_baud == BIT_LAST)
        begin
          state_next.rx_st = USD_IDLE;
          rx_done = 1'b1;
        end
      end
      default: state_next.rx_st = USD_IDLE;
    endcase

    // receive buffer: pop on read first, then push the arrival
    head = state_reg.rx_mem[state_reg.rx_rd];
    if (rd_shadow && state_reg.rx_cnt != '0)
    begin
      state_next.rx_rd = rx_inc(state_reg.rx_rd);
      state_next.rx_cnt = RCW'(state_reg.rx_cnt - 1'b1);
    end
    if (rx_done)
    begin
      ev[usd_pkg::INT_RX_BIT] = 1'b1;
      if (state_next.rx_cnt < rx_cap)
      begin
        state_next.rx_mem[state_reg.rx_wr] = state_reg.rx_shift;
        state_next.rx_wr = rx_inc(state_reg.rx_wr);
        state_next.rx_cnt = RCW'(state_next.rx_cnt + 1'b1);
      end
      else if (!state_reg.fifo_en)
      begin
        state_next.rx_mem[state_next.rx_rd] = state_reg.rx_shift;
        ev[usd_pkg::INT_OVERRUN_BIT] = 1'b1;
      end
      else
        ev[usd_pkg::INT_OVERRUN_BIT] = 1'b1;
    end

    // transmit shifter; loading the shift register frees the holding slot
    case (state_reg.tx_st)
      USD_IDLE:
      begin
        state_next.tx_line = 1'b1;
        if (state_reg.tx_cnt != '0)
        begin
          state_next.tx_shift = state_reg.tx_mem[state_reg.tx_rd];
          state_next.tx_rd = tx_inc(state_reg.tx_rd);
          state_next.tx_cnt = TCW'(state_reg.tx_cnt - 1'b1);
          state_next.tx_baud = 16'h0000;
          state_next.tx_line = 1'b0;
          state_next.tx_st = USD_START;
          if (state_reg.tx_cnt == TCW'(1))
            ev[usd_pkg::INT_TX_EMPTY_BIT] = 1'b1;
        end
      end
      USD_START:
      begin
        state_next.tx_baud = 16'(state_reg.tx_baud + 16'h0001);
        if (state_reg.tx_baud == BIT_LAST)
        begin
          state_next.tx_baud = 16'h0000;
          state_next.tx_bit = 3'h0;
          state_next.tx_line = state_reg.tx_shift[0];
          state_next.tx_st = USD_DATA;
        end
      end
      USD_DATA:
      begin
        state_next.tx_baud = 16'(state_reg.tx_baud + 16'h0001);
        if (state_reg.tx_baud == BIT_LAST)
        begin
          state_next.tx_baud = 16'h0000;
          state_next.tx_bit = 3'(state_reg.tx_bit + 3'h1);
          state_next.tx_shift = {1'b0, state_reg.tx_shift[7:1]};
          state_next.tx_line = state_reg.tx_shift[1];
          if (state_reg.tx_bit == 3'h7)
          begin
            state_next.tx_line = 1'b1;
            state_next.tx_st = USD_STOP;
          end
        end
      end
      USD_STOP:
      begin
        state_next.tx_baud = 16'(state_reg.tx_baud + 16'h0001);
        if (state_reg.tx_baud == BIT_LAST)
          state_next.tx_st = USD_IDLE;
      end
      default: state_next.tx_st = USD_IDLE;
    endcase

    // transmit buffer write
    if (wr_shadow)
    begin
      if (state_next.tx_cnt < tx_cap)
      begin
        state_next.tx_mem[state_reg.tx_wr] = WDATA[7:0];
        state_next.tx_wr = tx_inc(state_reg.tx_wr);
        state_next.tx_cnt = TCW'(state_next.tx_cnt + 1'b1);
      end
      else if (!state_reg.fifo_en)
        state_next.tx_mem[state_next.tx_rd] = WDATA[7:0];
      else
        ev[usd_pkg::INT_TX_LOST_BIT] = 1'b1;
    end

    // control and interrupt registers
    if (WR && ADDR == usd_pkg::FIFO_CONTROL_ADDR)
    begin
      state_next.fifo_en = WDATA[usd_pkg::FC_FIFO_EN_BIT];
      state_next.ir_mode = WDATA[usd_pkg::FC_IR_MODE_BIT];
      // a fifo enable change empties both buffers so depths never mix
      if (WDATA[usd_pkg::FC_FIFO_EN_BIT] != state_reg.fifo_en)
      begin
        state_next.rx_rd = '0;
        state_next.rx_wr = '0;
        state_next.rx_cnt = '0;
        state_next.tx_rd = '0;
        state_next.tx_wr = '0;
        state_next.tx_cnt = '0;
      end
    end
    if (WR && ADDR == usd_pkg::INT_MASK_ADDR)
      state_next.int_mask = WDATA[IW-1:0];
    if (WR && ADDR == usd_pkg::INT_STATUS_ADDR)
      state_next.int_stat = state_reg.int_stat & ~WDATA[IW-1:0];
    state_next.int_stat = state_next.int_stat | ev;
    // overrun clears on a line status read unless a new one arrives
    if (RD && ADDR == usd_pkg::LINE_STATUS_ADDR)
      state_next.overrun = 1'b0;
    if (ev[usd_pkg::INT_OVERRUN_BIT])
      state_next.overrun = 1'b1;

    // read data, valid the cycle after the strobe only
    state_next.rdata = usd_pkg::DATA_RESET;
    if (rd_shadow)
      state_next.rdata = {24'h000000,
        (state_reg.rx_cnt != '0) ? head : usd_pkg::CHAR_RESET};
    else if (RD && ADDR == usd_pkg::FIFO_CONTROL_ADDR)
    begin
      state_next.rdata[usd_pkg::FC_FIFO_EN_BIT] = state_reg.fifo_en;
      state_next.rdata[usd_pkg::FC_IR_MODE_BIT] = state_reg.ir_mode;
    end
    else if (RD && ADDR == usd_pkg::LINE_STATUS_ADDR)
    begin
      state_next.rdata[usd_pkg::LS_DATA_READY_BIT] =
        state_reg.rx_cnt != '0;
      state_next.rdata[usd_pkg::LS_OVERRUN_BIT] = state_reg.overrun;
      state_next.rdata[usd_pkg::LS_TX_EMPTY_BIT] =
        state_reg.tx_cnt == '0;
    end
    else if (RD && ADDR == usd_pkg::INT_STATUS_ADDR)
      state_next.rdata[IW-1:0] = state_reg.int_stat;
    else if (RD && ADDR == usd_pkg::INT_MASK_ADDR)
      state_next.rdata[IW-1:0] = state_reg.int_mask;

    state_next.irq = |(state_next.int_stat & state_next.int_mask);
    state_next.sout = state_next.ir_mode ? 1'b1 : state_next.tx_line;
    // infrared output goes low for each zero bit
    state_next.sir_out_n = state_next.ir_mode ? state_next.tx_line
      : 1'b1;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      state_reg <= '0;
      state_reg.sin_s1 <= 1'b1;
      state_reg.sin_s2 <= 1'b1;
      state_reg.tx_line <= 1'b1;
      state_reg.sout <= 1'b1;
      state_reg.sir_out_n <= 1'b1;
      state_reg.int_stat <= usd_pkg::INT_RESET;
      state_reg.int_mask <= usd_pkg::INT_RESET;
    end
    else if (CE)
      state_reg <= state_next;
  end

  assign RDATA = state_reg.rdata;
  assign SOUT = state_reg.sout;
  assign SIR_OUT_N = state_reg.sir_out_n;
  assign IRQ = state_reg.irq;
endmodule

// ==== usd_chk.sv ====
// pin-level assertions for the shadow data port
module usd_chk #(
  parameter int unsigned CLKS_PER_BIT = 8
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [31:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic SOUT,
  input wire logic SIR_OUT_N,
  input wire logic IRQ
);
  logic [15:0] lo_reg;
  logic [15:0] irl_reg;
  logic [15:0] idle_reg;
  wire shadow = ADDR >= usd_pkg::SHADOW_BASE && ADDR < usd_pkg::SHADOW_END;
  wire mapped = shadow || (ADDR >= usd_pkg::FIFO_CONTROL_ADDR
    && ADDR <= usd_pkg::INT_MASK_ADDR);
  // run lengths of low and idle line, a whole frame fits the widths
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      lo_reg <= 16'h0000;
      irl_reg <= 16'h0000;
      idle_reg <= 16'h0000;
    end
    else
    begin
      lo_reg <= SOUT ? 16'h0000 : lo_reg + 16'h0001;
      irl_reg <= SIR_OUT_N ? 16'h0000 : irl_reg + 16'h0001;
      idle_reg <= (SOUT && SIR_OUT_N) ? idle_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_read;
    CE && RD;
  endsequence
  sequence s_tx_start;
    !SOUT || !SIR_OUT_N;
  endsequence
  a_rdata_idle: assert property ($past(CE) && !$past(CE && RD)
    |-> RDATA == 32'h0) else $error("read data outside read slot");
  a_rdata_upper: assert property (RDATA[31:8] == 24'h0)
    else $error("reserved read bits set");
  a_unmapped_zero: assert property (s_read ##0 !mapped |=>
    RDATA == 32'h0) else $error("unmapped read not zero");
  a_reset_idle: assert property ($rose(RST_N) |-> SOUT && SIR_OUT_N
    && !IRQ && RDATA == 32'h0) else $error("pins wrong after reset");
  a_start_run: assert property ($rose(SOUT) |-> lo_reg != 0 &&
    lo_reg % CLKS_PER_BIT == 0 && lo_reg <= 9 * CLKS_PER_BIT)
    else $error("serial low run not whole bits");
  a_ir_run: assert property ($rose(SIR_OUT_N) |-> irl_reg != 0 &&
    irl_reg % CLKS_PER_BIT == 0 && irl_reg <= 9 * CLKS_PER_BIT)
    else $error("infrared low run not whole bits");
  a_pins_apart: assert property (!SIR_OUT_N |-> SOUT)
    else $error("both transmit pins active");
  a_tx_launch: assert property (CE && WR && shadow &&
    idle_reg > 10 * CLKS_PER_BIT |-> ##[1:4] s_tx_start)
    else $error("idle write did not start a frame");
endmodule

// ==== usd_partner.sv ====
// remote serial partner: sends on serial or infrared, receives frames
module usd_partner #(
  parameter int unsigned CPB = 8
) (
  input wire logic clk,
  input wire logic ir,
  output logic sin,
  output logic sir_in,
  input wire logic sout,
  input wire logic sir_out_n
);
  wire line = ir ? sir_out_n : sout;
  initial
  begin
    sin = 1'b1;
    sir_in = 1'b0;
  end
  // called right after a clock edge; 8N1, lsb first
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      if (ir)
        sir_in <= ~f[i];
      else
        sin <= f[i];
      repeat (CPB) @(posedge clk);
    end
    // the stop bit already leaves the infrared line idle
  endtask
  // ends mid stop bit so a low last data bit is not taken as a start
  task automatic recv(output logic [7:0] c);
    do @(posedge clk); while (line);
    repeat (CPB / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (CPB) @(posedge clk);
      c[i] = line;
    end
    repeat (CPB) @(posedge clk);
  endtask
endmodule

// ==== usd_shadow_port_bench.sv ====
// testbench for the shadow data port
bind usd_shadow_port usd_chk #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_usd_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WR(WR),
  .RD(RD), .RDATA(RDATA), .SOUT(SOUT), .SIR_OUT_N(SIR_OUT_N), .IRQ(IRQ));
module usd_shadow_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CPB = 8;
  localparam logic [31:0] B = usd_pkg::SHADOW_BASE;
  localparam logic [31:0] LS = usd_pkg::LINE_STATUS_ADDR;
  localparam logic [31:0] IS = usd_pkg::INT_STATUS_ADDR;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic CE = 1'b1;
  logic [31:0] ADDR = 32'h0;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic ir_sel = 1'b0;
  logic [31:0] RDATA;
  logic SIN;
  logic SIR_IN;
  logic SOUT;
  logic SIR_OUT_N;
  logic IRQ;
  logic [31:0] q;
  logic [7:0] c;
  int bad_count = 0;
  int tests_run = 0;
  always #10 REF_CLK = ~REF_CLK;
  usd_shadow_port #(.CLKS_PER_BIT(CPB)) u_usd_shadow_port (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SIN(SIN),
    .SIR_IN(SIR_IN), .SOUT(SOUT), .SIR_OUT_N(SIR_OUT_N), .IRQ(IRQ));
  usd_partner #(.CPB(CPB)) u_usd_partner (
    .clk(REF_CLK), .ir(ir_sel), .sin(SIN), .sir_in(SIR_IN),
    .sout(SOUT), .sir_out_n(SIR_OUT_N));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // bus tasks leave one idle cycle so strobes never re-rise in one step
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1 q = RDATA;
    @(posedge REF_CLK);
    chk(q, exp);
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    bad_count++;
    conclude();
  end
  initial
  begin
    repeat (5) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    rd(usd_pkg::SHADOW_DATA_2_ADDR, 32'h0);
    rd(LS, 32'h20);
    rd(B - 32'h4, 32'h0);
    // clock enable low: the mask write must leave no trace
    CE <= 1'b0;
    wr(usd_pkg::INT_MASK_ADDR, 32'hF);
    CE <= 1'b1;
    rd(usd_pkg::INT_MASK_ADDR, 32'h0);
    u_usd_partner.send(8'hA5);
    u_usd_partner.send(8'h3C);
    repeat (4) @(posedge REF_CLK);
    rd(LS, 32'h23);
    rd(B + 32'h3C, 32'h3C);
    rd(LS, 32'h20);
    rd(IS, 32'h3);
    wr(usd_pkg::INT_MASK_ADDR, 32'h2);
    // irq was launched one edge back; read before this edge updates it
    chk({31'h0, IRQ}, 32'h1);
    wr(IS, 32'h2);
    rd(IS, 32'h1);
    chk({31'h0, IRQ}, 32'h0);
    wr(IS, 32'hF);
    fork
      begin
        u_usd_partner.recv(c);
        chk({24'h0, c}, 32'h55);
        u_usd_partner.recv(c);
        chk({24'h0, c}, 32'hC3);
      end
      begin
        wr(B, 32'h55);
        repeat (4) @(posedge REF_CLK);
        wr(B + 32'h8, 32'h66);
        rd(LS, 32'h0);
        wr(usd_pkg::SHADOW_DATA_3_ADDR, 32'hC3);
      end
    join
    repeat (CPB) @(posedge REF_CLK);
    // infrared with buffers: fill receive past full, then drain
    // partner switched first so its first start bit goes out infrared
    ir_sel <= 1'b1;
    wr(usd_pkg::FIFO_CONTROL_ADDR, 32'h3);
    for (int i = 0; i < 17; i++)
      u_usd_partner.send(8'h10 + i[7:0]);
    repeat (4) @(posedge REF_CLK);
    rd(LS, 32'h23);
    for (int i = 0; i < 16; i++)
      rd(B + 32'(4 * i), 32'h10 + 32'(i));
    rd(LS, 32'h20);
    wr(IS, 32'hF);
    fork
      for (int i = 0; i < 17; i++)
      begin
        u_usd_partner.recv(c);
        chk({24'h0, c}, 32'h40 + 32'(i));
      end
      begin
        for (int i = 0; i < 18; i++)
          wr(B, 32'h40 + 32'(i));
        rd(IS, 32'hC);
      end
    join
    repeat (2 * CPB) @(posedge REF_CLK);
    rd(LS, 32'h20);
    conclude();
  end
endmodule
